// File: hw/accel_motion_pkg.sv
// shared constants, register map and carrier types of the motion and offset core
package accel_motion_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and shifts
  localparam int SAMPLE_W     = 13;
  localparam int OUT_W        = 16;
  localparam int RATE_W       = 4;
  localparam int IDX_W        = 6;
  localparam int DEC_W        = 16;
  localparam int FILT_SHIFT   = 2;
  localparam int THRESH_SHIFT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TAP_THRESH  = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_X_OFS       = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_Y_OFS       = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_Z_OFS       = 6'h20;
  localparam logic [IDX_W-1:0] IDX_TAP_DUR     = 6'h21;
  localparam logic [IDX_W-1:0] IDX_ACT_THRESH  = 6'h24;
  localparam logic [IDX_W-1:0] IDX_INACT_THR   = 6'h25;
  localparam logic [IDX_W-1:0] IDX_INACT_TIME  = 6'h26;
  localparam logic [IDX_W-1:0] IDX_ACT_CTRL    = 6'h27;
  localparam logic [IDX_W-1:0] IDX_TAP_AXES    = 6'h2a;
  localparam logic [IDX_W-1:0] IDX_STATUS      = 6'h2b;
  localparam logic [IDX_W-1:0] IDX_RATE        = 6'h2c;
  localparam logic [IDX_W-1:0] IDX_CAUSE       = 6'h30;
  localparam logic [IDX_W-1:0] IDX_FORMAT      = 6'h31;
  localparam logic [IDX_W-1:0] IDX_X_OUT       = 6'h32;
  localparam logic [IDX_W-1:0] IDX_Y_OUT       = 6'h33;
  localparam logic [IDX_W-1:0] IDX_Z_OUT       = 6'h34;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int TAP_ENH_BIT    = 3;
  localparam int STAT_ASLEEP    = 3;
  localparam int STAT_SIGN_LSB  = 4;
  localparam int LOW_POWER_BIT  = 4;
  localparam int FULL_RES_BIT   = 3;
  localparam int LINK_BIT       = 0;
  localparam int AUTO_SLEEP_BIT = 1;
  localparam int ACT_EN_BIT     = 2;
  localparam int INACT_EN_BIT   = 3;
  localparam int CAUSE_DREADY   = 7;
  localparam int CAUSE_TAP      = 6;
  localparam int CAUSE_ACT      = 4;
  localparam int CAUSE_INACT    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // rate codes and reset values
  localparam logic [RATE_W-1:0] MAX_RATE_CODE   = 4'hf;
  localparam logic [RATE_W-1:0] SLEEP_RATE_RST  = 4'h3;
  localparam logic [7:0]        OFS_RST         = 8'h00;
  localparam logic [7:0]        RATE_RST        = 8'h0a;
  localparam logic [7:0]        ZERO_RST        = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] x;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] z;
  } accel_s;

  typedef struct packed {
    logic [2:0][7:0] ofs;
    logic [7:0]      tap_thr;
    logic [7:0]      tap_dur;
    logic [7:0]      act_thr;
    logic [7:0]      inact_thr;
    logic [7:0]      inact_time;
    logic [7:0]      act_ctrl;
    logic [7:0]      tap_axes;
    logic [7:0]      rate;
    logic [7:0]      format;
  } cfg_s;

  localparam cfg_s CFG_RST = '{ofs: {OFS_RST, OFS_RST, OFS_RST}, tap_thr: ZERO_RST, tap_dur: ZERO_RST,
                               act_thr: ZERO_RST, inact_thr: ZERO_RST, inact_time: ZERO_RST,
                               act_ctrl: ZERO_RST, tap_axes: ZERO_RST, rate: RATE_RST, format: ZERO_RST};

  typedef enum logic {
    TAP_IDLE = 1'b0,
    TAP_HIGH = 1'b1
  } tap_state_e;

endpackage

// File: hw/offset_adder.sv
// per-axis offset scaling and saturating addition
module offset_adder
  import accel_motion_pkg::*;
(
  input  wire logic signed [SAMPLE_W-1:0] sample,
  input  wire logic        [7:0]          offset,
  input  wire logic                       full_res,
  input  wire logic        [1:0]          range,
  output logic signed      [OUT_W-1:0]    result
);

  localparam int SW = SAMPLE_W + 3;

  logic signed [SW-1:0]       ofs_ext;
  logic signed [SW-1:0]       scaled;
  logic signed [SW-1:0]       sum;
  logic signed [SW-1:0]       max_v;
  logic signed [SW-1:0]       min_v;
  logic signed [SAMPLE_W-1:0] clamped;

  always_comb begin
    ofs_ext = SW'(signed'(offset));
    max_v   = SW'((1 << (SAMPLE_W - 1)) - 1);
    min_v   = -max_v - SW'(1);
    // one offset step is a fixed acceleration, scaled to the output step
    if (full_res) begin
      scaled = ofs_ext <<< 2; // R16
    end else begin
      case (range) // R15
        2'h0:    scaled = ofs_ext <<< 2;
        2'h1:    scaled = ofs_ext <<< 1;
        2'h2:    scaled = ofs_ext;
        default: scaled = ofs_ext >>> 1;
      endcase
    end
    sum = SW'(sample) + scaled; // R14
    if (sum > max_v) begin
      clamped = max_v[SAMPLE_W-1:0]; // R20
    end else if (sum < min_v) begin
      clamped = min_v[SAMPLE_W-1:0]; // R20
    end else begin
      clamped = sum[SAMPLE_W-1:0];
    end
    result = OUT_W'(clamped);
  end

endmodule

// File: hw/motion_offset_core.sv
// motion detection, link and auto-sleep sequencing, offset correction and apb registers
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1 - enhanced tap runs on filtered output-rate data
// R2 - enhanced tap uses ac-coupled sample differences
// R3 - software keeps tap timings above one step
// R4 - negative acceleration reports negative tap sign
// R5 - output rates decimate one common sample stream
// R6 - activity and normal tap use undecimated samples
// R7 - with link, activity armed only after inactivity
// R8 - reading interrupt cause clears pending flags
// R9 - no auto-sleep while activity flag pending
// R10 - status shows asleep bit while sleeping
// R11 - low power keeps data ready and samples
// R12 - inactivity sleeps, slows rate, swaps detectors
// R13 - activity wakes, restores rate, swaps detectors
// R14 - per-axis signed offset added to samples
// R15 - offset step fixed, rescaled to resolution
// R16 - full resolution shifts offset left two
// R17 - offsets return to zero on reset
// R18 - software negates and rounds measured error
// R19 - software averages enough samples when calibrating
// R20 - corrected sum saturates instead of wrapping
////////////////////////////////////////////////////////////////////////////////
module motion_offset_core
  import accel_motion_pkg::*;
#(
  parameter logic [RATE_W-1:0] SLEEP_RATE_CODE = SLEEP_RATE_RST
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         sample_valid,
  input  wire accel_s       sample,
  output logic              data_ready,
  output logic              asleep,
  output logic              low_power_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  cfg_s                       cfg_ff, nxt_cfg;
  logic [31:0]                prdata_ff, nxt_prdata, rd_word;
  logic                       err_ff, nxt_err, rd_err;
  logic [7:0]                 cause_ff, nxt_cause, cause_set, cause_clr;
  logic [7:0]                 status_ff, nxt_status;
  logic [IDX_W-1:0]           idx;
  logic                       cause_read;

  logic signed [SAMPLE_W-1:0] raw        [3];
  logic signed [SAMPLE_W-1:0] filt_ff    [3];
  logic signed [SAMPLE_W-1:0] nxt_filt   [3];
  logic signed [SAMPLE_W-1:0] prev_ff    [3];
  logic signed [SAMPLE_W-1:0] nxt_prev   [3];
  logic signed [SAMPLE_W:0]   fdiff      [3];
  logic signed [OUT_W-1:0]    out_ff     [3];
  logic signed [OUT_W-1:0]    nxt_out    [3];
  logic signed [OUT_W-1:0]    adj        [3];
  logic [DEC_W-1:0]           dec_cnt_ff, nxt_dec, div_m1;
  logic [RATE_W-1:0]          rate_code;
  logic                       odr_tick;
  logic                       data_ready_ff, nxt_dready;

  tap_state_e                 tap_state_ff, nxt_tap_state;
  logic [7:0]                 tap_cnt_ff, nxt_tap_cnt;
  logic [2:0]                 tap_axis_ff, nxt_tap_axis;
  logic [2:0]                 tap_neg_ff, nxt_tap_neg;
  logic signed [SAMPLE_W:0]   tap_val    [3];
  logic [2:0]                 over, first, negm;
  logic [SAMPLE_W:0]          tap_lim, act_lim, inact_lim;
  logic                       enh, tap_valid, tap_event;

  logic                       act_armed_ff, nxt_act_armed;
  logic                       inact_armed_ff, nxt_inact_armed;
  logic                       asleep_ff, nxt_asleep;
  logic [7:0]                 quiet_cnt_ff, nxt_quiet_cnt;
  logic                       link_on, auto_on, act_eff, inact_eff;
  logic                       act_over, quiet, act_event, inact_event;

  function automatic logic [SAMPLE_W:0] mag(input logic signed [SAMPLE_W:0] v);
    mag = v[SAMPLE_W] ? (SAMPLE_W + 1)'(-v) : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb register file
  assign idx        = paddr[IDX_W+1:2];
  assign cause_read = psel && penable && !pwrite && (idx == IDX_CAUSE) && !err_ff;

  always_comb begin
    nxt_cfg = cfg_ff;
    rd_word = '0;
    rd_err  = (paddr[1:0] != 2'b00);
    case (idx)
      IDX_TAP_THRESH: rd_word[7:0] = cfg_ff.tap_thr;
      IDX_X_OFS:      rd_word[7:0] = cfg_ff.ofs[0];
      IDX_Y_OFS:      rd_word[7:0] = cfg_ff.ofs[1];
      IDX_Z_OFS:      rd_word[7:0] = cfg_ff.ofs[2];
      IDX_TAP_DUR:    rd_word[7:0] = cfg_ff.tap_dur;
      IDX_ACT_THRESH: rd_word[7:0] = cfg_ff.act_thr;
      IDX_INACT_THR:  rd_word[7:0] = cfg_ff.inact_thr;
      IDX_INACT_TIME: rd_word[7:0] = cfg_ff.inact_time;
      IDX_ACT_CTRL:   rd_word[7:0] = cfg_ff.act_ctrl;
      IDX_TAP_AXES:   rd_word[7:0] = cfg_ff.tap_axes;
      IDX_STATUS:     rd_word[7:0] = {status_ff[7:4], asleep_ff, status_ff[2:0]}; // R10
      IDX_RATE:       rd_word[7:0] = cfg_ff.rate;
      IDX_CAUSE:      rd_word[7:0] = cause_ff;
      IDX_FORMAT:     rd_word[7:0] = cfg_ff.format;
      IDX_X_OUT:      rd_word[OUT_W-1:0] = out_ff[0];
      IDX_Y_OUT:      rd_word[OUT_W-1:0] = out_ff[1];
      IDX_Z_OUT:      rd_word[OUT_W-1:0] = out_ff[2];
      default:        rd_err = 1'b1;
    endcase
    if (psel && penable && pwrite && !err_ff) begin
      case (idx)
        IDX_TAP_THRESH: nxt_cfg.tap_thr    = pwdata[7:0];
        IDX_X_OFS:      nxt_cfg.ofs[0]     = pwdata[7:0];
        IDX_Y_OFS:      nxt_cfg.ofs[1]     = pwdata[7:0];
        IDX_Z_OFS:      nxt_cfg.ofs[2]     = pwdata[7:0];
        IDX_TAP_DUR:    nxt_cfg.tap_dur    = pwdata[7:0];
        IDX_ACT_THRESH: nxt_cfg.act_thr    = pwdata[7:0];
        IDX_INACT_THR:  nxt_cfg.inact_thr  = pwdata[7:0];
        IDX_INACT_TIME: nxt_cfg.inact_time = pwdata[7:0];
        IDX_ACT_CTRL:   nxt_cfg.act_ctrl   = pwdata[7:0];
        IDX_TAP_AXES:   nxt_cfg.tap_axes   = pwdata[7:0];
        IDX_RATE:       nxt_cfg.rate       = pwdata[7:0];
        IDX_FORMAT:     nxt_cfg.format     = pwdata[7:0];
        default:        nxt_cfg = cfg_ff;
      endcase
    end
    // read data and error are latched in the setup cycle
    nxt_prdata = (psel && !penable) ? rd_word : prdata_ff;
    nxt_err    = (psel && !penable) ? rd_err : err_ff;
    // only bits the host actually saw are cleared, a new event wins
    cause_set  = {odr_tick, tap_event, 1'b0, act_event, inact_event, 3'b000};
    cause_clr  = cause_read ? prdata_ff[7:0] : 8'h00;
    nxt_cause  = (cause_ff & ~cause_clr) | cause_set; // R8
    nxt_status = tap_event ? {1'b0, tap_neg_ff, 1'b0, tap_axis_ff} : status_ff;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ff    <= CFG_RST; // R17
      prdata_ff <= '0;
      err_ff    <= 1'b0;
      cause_ff  <= '0;
      status_ff <= '0;
    end else begin
      cfg_ff    <= nxt_cfg;
      prdata_ff <= nxt_prdata;
      err_ff    <= nxt_err;
      cause_ff  <= nxt_cause;
      status_ff <= nxt_status;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && err_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sample path: decimation, filter, offset correction
  assign raw[0] = sample.x;
  assign raw[1] = sample.y;
  assign raw[2] = sample.z;

  generate
    for (genvar a = 0; a < 3; a++) begin : g_axis
      offset_adder u_ofs (
        .sample   (filt_ff[a]),
        .offset   (cfg_ff.ofs[a]),
        .full_res (cfg_ff.format[FULL_RES_BIT]),
        .range    (cfg_ff.format[1:0]),
        .result   (adj[a])
      );
    end
  endgenerate

  always_comb begin
    rate_code  = asleep_ff ? SLEEP_RATE_CODE : cfg_ff.rate[RATE_W-1:0]; // R12
    div_m1     = (DEC_W'(1) << (MAX_RATE_CODE - rate_code)) - DEC_W'(1); // R5
    odr_tick   = sample_valid && (dec_cnt_ff >= div_m1); // R5
    nxt_dec    = !sample_valid ? dec_cnt_ff : (odr_tick ? '0 : dec_cnt_ff + DEC_W'(1));
    nxt_dready = odr_tick; // R11
    for (int a = 0; a < 3; a++) begin
      fdiff[a]    = (SAMPLE_W + 1)'(raw[a]) - (SAMPLE_W + 1)'(filt_ff[a]);
      nxt_filt[a] = sample_valid ? filt_ff[a] + SAMPLE_W'(fdiff[a] >>> FILT_SHIFT) : filt_ff[a];
      nxt_prev[a] = odr_tick ? filt_ff[a] : prev_ff[a];
      nxt_out[a]  = odr_tick ? adj[a] : out_ff[a]; // R14
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dec_cnt_ff    <= '0;
      data_ready_ff <= 1'b0;
      for (int a = 0; a < 3; a++) begin
        filt_ff[a] <= '0;
        prev_ff[a] <= '0;
        out_ff[a]  <= '0;
      end
    end else begin
      dec_cnt_ff    <= nxt_dec;
      data_ready_ff <= nxt_dready;
      for (int a = 0; a < 3; a++) begin
        filt_ff[a] <= nxt_filt[a];
        prev_ff[a] <= nxt_prev[a];
        out_ff[a]  <= nxt_out[a];
      end
    end
  end

  assign data_ready     = data_ready_ff;
  assign low_power_mode = cfg_ff.rate[LOW_POWER_BIT]; // R11

  ////////////////////////////////////////////////////////////////////////////
  // tap detection
  always_comb begin
    enh       = cfg_ff.tap_axes[TAP_ENH_BIT];
    tap_lim   = (SAMPLE_W + 1)'(cfg_ff.tap_thr) << THRESH_SHIFT;
    tap_valid = enh ? odr_tick : sample_valid; // R1 R6
    for (int a = 0; a < 3; a++) begin
      tap_val[a]  = enh ? (SAMPLE_W + 1)'(filt_ff[a]) - (SAMPLE_W + 1)'(prev_ff[a]) // R2
                        : (SAMPLE_W + 1)'(raw[a]);
      over[2-a]   = cfg_ff.tap_axes[2-a] && (mag(tap_val[a]) >= tap_lim);
      negm[2-a]   = over[2-a] && tap_val[a][SAMPLE_W]; // R4
    end
    first         = {over[2], over[1] && !over[2], over[0] && !over[1] && !over[2]};
    nxt_tap_state = tap_state_ff;
    nxt_tap_cnt   = tap_cnt_ff;
    nxt_tap_axis  = tap_axis_ff;
    nxt_tap_neg   = tap_neg_ff;
    tap_event     = 1'b0;
    unique case (tap_state_ff)
      TAP_IDLE: begin
        if (tap_valid && (|over)) begin
          nxt_tap_state = TAP_HIGH;
          nxt_tap_cnt   = 8'h01;
          nxt_tap_axis  = first;
          nxt_tap_neg   = negm; // R4
        end
      end
      TAP_HIGH: begin
        if (tap_valid) begin
          if (|over) begin
            nxt_tap_cnt = (tap_cnt_ff != 8'hff) ? tap_cnt_ff + 8'h01 : tap_cnt_ff;
          end else begin
            nxt_tap_state = TAP_IDLE;
            tap_event     = (tap_cnt_ff <= cfg_ff.tap_dur);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tap_state_ff <= TAP_IDLE;
      tap_cnt_ff   <= '0;
      tap_axis_ff  <= '0;
      tap_neg_ff   <= '0;
    end else begin
      tap_state_ff <= nxt_tap_state;
      tap_cnt_ff   <= nxt_tap_cnt;
      tap_axis_ff  <= nxt_tap_axis;
      tap_neg_ff   <= nxt_tap_neg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // activity, inactivity, link and auto-sleep
  always_comb begin
    link_on   = cfg_ff.act_ctrl[LINK_BIT];
    auto_on   = cfg_ff.act_ctrl[AUTO_SLEEP_BIT];
    act_lim   = (SAMPLE_W + 1)'(cfg_ff.act_thr) << THRESH_SHIFT;
    inact_lim = (SAMPLE_W + 1)'(cfg_ff.inact_thr) << THRESH_SHIFT;
    act_eff   = !link_on || act_armed_ff; // R7
    inact_eff = !link_on || inact_armed_ff;
    act_over  = 1'b0;
    quiet     = 1'b1;
    for (int a = 0; a < 3; a++) begin
      if (mag((SAMPLE_W + 1)'(raw[a])) >= act_lim) begin
        act_over = 1'b1; // R6
      end
      if (mag((SAMPLE_W + 1)'(raw[a])) >= inact_lim) begin
        quiet = 1'b0;
      end
    end
    act_event   = sample_valid && cfg_ff.act_ctrl[ACT_EN_BIT] && act_eff && act_over;
    inact_event = sample_valid && cfg_ff.act_ctrl[INACT_EN_BIT] && inact_eff && quiet &&
                  (quiet_cnt_ff >= cfg_ff.inact_time);
    nxt_quiet_cnt = quiet_cnt_ff;
    if (sample_valid) begin
      nxt_quiet_cnt = (!quiet || inact_event) ? 8'h00 :
                      ((quiet_cnt_ff != 8'hff) ? quiet_cnt_ff + 8'h01 : quiet_cnt_ff);
    end
    nxt_act_armed   = act_armed_ff;
    nxt_inact_armed = inact_armed_ff;
    if (!link_on) begin
      nxt_act_armed   = 1'b0;
      nxt_inact_armed = 1'b1;
    end else if (act_event) begin
      nxt_act_armed   = 1'b0; // R13
      nxt_inact_armed = 1'b1;
    end else if (inact_event) begin
      nxt_act_armed   = 1'b1; // R7 R12
      nxt_inact_armed = 1'b0;
    end
    nxt_asleep = asleep_ff;
    if (!(link_on && auto_on)) begin
      nxt_asleep = 1'b0;
    end else if (asleep_ff && act_event) begin
      nxt_asleep = 1'b0; // R13
    end else if (!asleep_ff && inact_event && !cause_ff[CAUSE_ACT] && !act_event) begin
      nxt_asleep = 1'b1; // R9 R12
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_armed_ff   <= 1'b0;
      inact_armed_ff <= 1'b1;
      asleep_ff      <= 1'b0;
      quiet_cnt_ff   <= '0;
    end else begin
      act_armed_ff   <= nxt_act_armed;
      inact_armed_ff <= nxt_inact_armed;
      asleep_ff      <= nxt_asleep;
      quiet_cnt_ff   <= nxt_quiet_cnt;
    end
  end

  assign asleep = asleep_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_sleep_entry;
    inact_event && link_on && auto_on && !asleep_ff && !cause_ff[CAUSE_ACT] && !act_event;
  endsequence

  sequence s_wake;
    asleep_ff && act_event && link_on && auto_on;
  endsequence

  sequence s_status_setup;
    psel && !penable && (idx == IDX_STATUS) && (paddr[1:0] == 2'b00);
  endsequence

  AST_ENH_TAP_AT_ODR: assert property (@(posedge clk) disable iff (!rstn) // R1
    (enh && tap_event) |-> odr_tick) else $error("enhanced tap outside an output-rate step");
  AST_TAP_SIGN: assert property (@(posedge clk) disable iff (!rstn) // R4
    tap_event |=> (status_ff[STAT_SIGN_LSB +: 3] == $past(tap_neg_ff)) && (status_ff[2:0] == $past(tap_axis_ff)))
    else $error("tap sign or source not reported");
  AST_DECIM_STREAM: assert property (@(posedge clk) disable iff (!rstn) // R5
    odr_tick |-> sample_valid ##1 (dec_cnt_ff == '0)) else $error("output step without internal sample");
  AST_UNDECIMATED_ACT: assert property (@(posedge clk) disable iff (!rstn) // R6
    (act_event || (!enh && tap_event)) |-> sample_valid) else $error("detector not on internal samples");
  AST_LINK_ARM: assert property (@(posedge clk) disable iff (!rstn) // R7
    (link_on && !act_armed_ff) |-> !act_event) else $error("activity raised while disarmed");
  AST_CAUSE_CLEAR: assert property (@(posedge clk) disable iff (!rstn) // R8
    (cause_read && prdata_ff[CAUSE_ACT] && !act_event) |=> !cause_ff[CAUSE_ACT])
    else $error("activity flag survived a cause read");
  AST_NO_SLEEP_PENDING: assert property (@(posedge clk) disable iff (!rstn) // R9
    $rose(asleep_ff) |-> !$past(cause_ff[CAUSE_ACT])) else $error("slept with activity pending");
  AST_ASLEEP_STATUS: assert property (@(posedge clk) disable iff (!rstn) // R10
    s_status_setup |=> prdata_ff[STAT_ASLEEP] == $past(asleep_ff)) else $error("asleep bit wrong");
  AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (!rstn) // R12
    s_sleep_entry |=> asleep_ff && act_armed_ff && !inact_armed_ff && (rate_code == SLEEP_RATE_CODE))
    else $error("sleep entry sequence wrong");
  AST_WAKE: assert property (@(posedge clk) disable iff (!rstn) // R13
    s_wake |=> !asleep_ff && cause_ff[CAUSE_ACT] && inact_armed_ff && !act_armed_ff)
    else $error("wake sequence wrong");
  AST_OUT_UPDATE: assert property (@(posedge clk) disable iff (!rstn) // R14
    (odr_tick ##1 !odr_tick) |-> data_ready_ff && (out_ff[0] == $past(adj[0])) ##1 !data_ready_ff)
    else $error("output register not updated");
  AST_OFS_RESET: assert property (@(posedge clk) disable iff (!rstn) // R17
    $rose(rstn) |-> (cfg_ff.ofs == '0)) else $error("offsets not zero after reset");

endmodule

// File: tb/host_model.sv
// apb host model that programs and services the motion core
module host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // offset code from a measured zero-g error in full-resolution steps
  function automatic logic [7:0] ofs_for(input int err);
    int mag;
    mag = ((err < 0 ? -err : err) + 2) / 4;
    return 8'(err > 0 ? -mag : mag);
  endfunction

  // one apb transfer; ok stays low if pready never comes
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      output logic [31:0] q, output logic e, output bit ok);
    ok = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        q = prdata;
        e = pslverr;
        ok = 1;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
    paddr <= ~paddr;
  endtask
endmodule

// File: tb/tap_sleep_offset_logic_test.sv
// self-checking bench of the motion and offset core
module tap_sleep_offset_logic_test import accel_motion_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, sample_valid, data_ready, asleep, low_power_mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  accel_s      sample;
  int          fails, samples_checked, dr_seen, dr_mark;

  motion_offset_core u_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                            .sample_valid, .sample, .data_ready, .asleep, .low_power_mode);
  host_model u_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (data_ready === 1'b1) dr_seen <= dr_seen + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic acc(input logic w, input logic [5:0] idx, input logic [7:0] d);
    bit ok;
    u_host.xfer(w, idx, d, q, e, ok);
    if (!ok) begin
      fails++;
      conclude();
    end
  endtask

  task automatic feed(input logic signed [12:0] x, y, z, input int n);
    repeat (n) begin
      @(posedge clk);
      sample_valid <= 1'b1;
      sample <= '{x: x, y: y, z: z};
      @(posedge clk);
      sample_valid <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      acc(0, IDX_X_OFS + 6'(i), 0);
      check("offset", q, 0);
    end
    acc(0, IDX_RATE, 0);
    check("rate", q, 32'(RATE_RST));
    acc(1, IDX_STATUS, 8'hff);
    acc(0, IDX_STATUS, 0);
    check("status", q, 0);
    check("idle_out", {data_ready, asleep, low_power_mode}, 0);
    acc(0, 6'h3f, 0);
    check("unmapped", {q[30:0], e}, 1);
    $display("reset test ended");
  endtask

  task automatic t_offset();
    acc(1, IDX_X_OFS, u_host.ofs_for(10));
    acc(1, IDX_Y_OFS, u_host.ofs_for(-13));
    acc(1, IDX_Z_OFS, u_host.ofs_for(9));
    acc(1, IDX_RATE, 8'h1f);
    acc(1, IDX_FORMAT, 8'h08);
    dr_mark = dr_seen;
    feed(0, 0, 0, 10);
    check("low_power", low_power_mode, 1);
    check("ready_pulses", dr_seen - dr_mark, 10);
    acc(0, IDX_X_OUT, 0);
    check("x_out", q, 32'h0000fff4);
    acc(0, IDX_Y_OUT, 0);
    check("y_out", q, 32'h0000000c);
    acc(0, IDX_Z_OUT, 0);
    check("z_out", q, 32'h0000fff8);
    for (int r = 0; r < 4; r++) begin
      acc(1, IDX_FORMAT, 8'(r));
      feed(0, 0, 0, 1);
      acc(0, IDX_X_OUT, 0);
      check("x_range", q, {16'h0, 16'(-12 >>> r)});
    end
    acc(1, IDX_X_OFS, 8'h7f);
    acc(1, IDX_Z_OFS, 8'h80);
    acc(1, IDX_FORMAT, 8'h08);
    feed(13'h0fff, 0, 13'h1000, 40);
    acc(0, IDX_X_OUT, 0);
    check("x_sat", q, 32'h00000fff);
    acc(0, IDX_Z_OUT, 0);
    check("z_sat", q, 32'h0000f000);
    acc(0, IDX_CAUSE, 0);
    check("cause_set", q[CAUSE_DREADY], 1);
    acc(0, IDX_CAUSE, 0);
    check("cause_clr", q[CAUSE_DREADY], 0);
    $display("offset test ended");
  endtask

  task automatic t_sleep();
    acc(1, IDX_ACT_THRESH, 8'h02);
    acc(1, IDX_INACT_THR, 8'h01);
    acc(1, IDX_INACT_TIME, 8'h04);
    acc(1, IDX_ACT_CTRL, 8'h0f);
    feed(13'sd100, 0, 0, 1);
    feed(0, 0, 0, 8);
    check("asleep", asleep, 1);
    acc(0, IDX_STATUS, 0);
    check("stat_asleep", q[STAT_ASLEEP], 1);
    acc(0, IDX_CAUSE, 0);
    check("inact_flag", q[CAUSE_INACT], 1);
    check("act_gated", q[CAUSE_ACT], 0);
    dr_mark = dr_seen;
    feed(0, 0, 0, 8);
    check("slow_rate", dr_seen - dr_mark, 0);
    acc(0, IDX_CAUSE, 0);
    check("inact_once", q[CAUSE_INACT], 0);
    feed(13'sd100, 0, 0, 1);
    check("awake", asleep, 0);
    dr_mark = dr_seen;
    feed(0, 0, 0, 12);
    check("rate_back", dr_seen - dr_mark, 12);
    check("held_awake", asleep, 0);
    acc(0, IDX_CAUSE, 0);
    check("act_flag", q[CAUSE_ACT], 1);
    acc(1, IDX_ACT_CTRL, 8'h00);
    $display("sleep test ended");
  endtask

  task automatic t_tap();
    acc(1, IDX_TAP_THRESH, 8'h02);
    acc(1, IDX_TAP_DUR, 8'h04);
    acc(1, IDX_TAP_AXES, 8'h04);
    feed(-13'sd100, 0, 0, 2);
    feed(0, 0, 0, 1);
    acc(0, IDX_STATUS, 0);
    check("tap_neg", q, 32'h44);
    feed(13'sd100, 0, 0, 2);
    feed(0, 0, 0, 1);
    acc(0, IDX_STATUS, 0);
    check("tap_pos", q, 32'h04);
    // settle the filter, then one large step seen as an output-rate difference
    feed(0, 0, 0, 40);
    acc(1, IDX_TAP_THRESH, 8'h08);
    acc(1, IDX_TAP_AXES, 8'h0c);
    feed(-13'sd2000, 0, 0, 1);
    feed(0, 0, 0, 2);
    acc(0, IDX_STATUS, 0);
    check("tap_enh", q, 32'h44);
    $display("tap test ended");
  endtask

  initial begin
    rstn = 1'b0;
    sample_valid = 1'b0;
    sample = '0;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_offset();
    t_sleep();
    t_tap();
    conclude();
  end
endmodule
